// file: flash_unsecure_regs.svh
// offsets, field positions, field values and counts of the backdoor unsecure block
// assumes byte-wide registers behind a plain strobe port
`ifndef FLASH_UNSECURE_REGS_SVH
`define FLASH_UNSECURE_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_SECURITY 8'h01
`define OFS_ECC_IDX 8'h02
`define OFS_CONFIG 8'h04
`define OFS_STATUS 8'h06
`define OFS_ERR_STATUS 8'h07
`define OFS_CMD_IDX 8'h08
`define OFS_CMD_HI 8'h0A
`define OFS_CMD_LO 8'h0B
`define OFS_ECC_HI 8'h0C
`define OFS_ECC_LO 8'h0D
`define OFS_ERR_MASK 8'h0E
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define CFG_IRQ_EN_BIT 7
`define CFG_IGN_SF_BIT 4
`define CFG_FORCE_DF_BIT 1
`define CFG_FORCE_SF_BIT 0
`define CFG_RW_MASK 8'h93
`define STAT_DONE_BIT 7
`define STAT_ACCESS_ERROR_FLAG_BIT 5
`define KEY_ENABLED 2'h2
`define SEC_UNSECURE 2'h2
`define KEY_BLANK_LO 16'h0000
`define KEY_BLANK_HI 16'hFFFF
`define VERIFY_KEY_CMD 8'h0C
`define LAUNCH_IDX 3'h4
`define INVALID_DATA 16'h0000
`define KEY_COUNT 4
`define PARAM_COUNT 5
`define ECC_WORDS 8
`endif

// file: flash_unsecure_pkg.sv
// types shared by the backdoor unsecure block
// assumes the constants header sits beside it
`include "flash_unsecure_regs.svh"
package flash_unsecure_pkg;
   typedef enum logic [1:0] {IDLE, CHECK, FINISH} fsm_t;
   typedef logic [`KEY_COUNT-1:0][15:0] key_set_t;
   typedef logic [`ECC_WORDS-1:0][15:0] ecc_set_t;
   typedef struct packed {
      logic irq_en;
      logic ignore_single_fault;
      logic force_double_fault;
      logic force_single_fault;
   } config_t;
   typedef struct packed {
      logic dbl;
      logic sgl;
   } fault_t;
   typedef struct packed {
      fsm_t fsm;
      logic [1:0] key_idx;
      logic all_match;
      logic cmd_done;
      logic acc_err;
      logic lockout;
      logic [1:0] security_state;
      logic [1:0] key_enable;
      config_t cfg;
      logic [2:0] ecc_idx;
      logic [2:0] cmd_idx;
      logic [`PARAM_COUNT-1:0][15:0] params;
      fault_t err_status;
      fault_t err_mask;
      logic [7:0] rd_data;
      logic [15:0] pf0_data;
      logic pf0_invalid;
   } state_t;
endpackage : flash_unsecure_pkg

// file: flash_backdoor_unsecure.sv
// backdoor key verification, security state and flash configuration register
// assumes one 40 MHz clock, synchronous reset, byte registers on a strobe port,
// stored keys, security byte and ecc results presented by the flash array
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "flash_unsecure_regs.svh"
// How it works
// - four stored 16-bit keys, each compared with its presented word
// - comparison runs only when the key enable field is enabled
// - full match forces security state to unsecure 10
// - stored keys 0x0000 or 0xFFFF never count as a match
// - program-flash block 0 reads return invalid data during verification
// - mismatch locks out later verifications until reset
// - success changes only the live security state, never the security byte
// - stored keys are never written by the verification
// - reset reloads security state from the security byte
// - unsecured state allows programming of the key locations
// - unsecured state allows erasing the security sector and reprogramming it
// - interrupt enable bit 7 gates the command done flag onto the interrupt
// - ignore bit 4 drops single-bit fault reports and their interrupt
// - config keeps only bits 7, 4, 1, 0; others read zero
// - ecc word index selects the ecc result word that is read
// - key enable counts as enabled only at 10, else access error
// - done flag sets again when verification ends, whatever the result
module flash_backdoor_unsecure (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [7:0] nv_security_i,
   input wire flash_unsecure_pkg::key_set_t stored_keys_i,
   input wire flash_unsecure_pkg::ecc_set_t ecc_results_i,
   input wire logic single_fault_i,
   input wire logic double_fault_i,
   input wire logic pf0_rd_req_i,
   input wire logic [15:0] pf0_array_data_i,
   output logic [15:0] pf0_rd_data_o,
   output logic pf0_rd_invalid_o,
   output flash_unsecure_pkg::fault_t force_fault_o,
   output logic [1:0] security_state_o,
   output logic key_program_allow_o,
   output logic sector_erase_allow_o,
   output logic irq_o
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic key_hit(input logic [15:0] stored, input logic [15:0] given);
      key_hit = (stored == given) && (stored != `KEY_BLANK_LO) && (stored != `KEY_BLANK_HI);
   endfunction : key_hit

   flash_unsecure_pkg::state_t st_reg;
   flash_unsecure_pkg::state_t st_next;
   logic launch;
   logic busy;
   logic hit;
   logic [15:0] ecc_word;
   flash_unsecure_pkg::fault_t err_set;
   flash_unsecure_pkg::fault_t err_clr;

   assign busy = (st_reg.fsm != flash_unsecure_pkg::IDLE);
   // launch is taken only while idle and with no access error pending
   assign launch = wr_i && (addr_i == `OFS_STATUS) && wdata_i[`STAT_DONE_BIT]
                   && st_reg.cmd_done && !st_reg.acc_err;
   assign hit = key_hit(stored_keys_i[st_reg.key_idx],
                        st_reg.params[st_reg.key_idx + 3'h1]);
   assign ecc_word = ecc_results_i[st_reg.ecc_idx];
   // one driver for the whole struct: {double, single}
   assign err_set = {double_fault_i, single_fault_i && !st_reg.cfg.ignore_single_fault};
   assign err_clr = (wr_i && addr_i == `OFS_ERR_STATUS) ? wdata_i[1:0] : 2'h0;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rd_data = 8'h00;
      // set wins over a same-cycle write-one clear
      st_next.err_status = (st_reg.err_status & ~err_clr) | err_set;
      // block 0 is not readable while the comparison walks it
      st_next.pf0_data = busy ? `INVALID_DATA : pf0_array_data_i;
      st_next.pf0_invalid = pf0_rd_req_i && busy;
      if (rd_i) begin
         unique case (addr_i)
            `OFS_SECURITY: st_next.rd_data = {st_reg.key_enable, 4'h0, st_reg.security_state};
            `OFS_ECC_IDX: st_next.rd_data = {5'h00, st_reg.ecc_idx};
            `OFS_CONFIG: st_next.rd_data = {st_reg.cfg.irq_en, 2'h0,
                                            st_reg.cfg.ignore_single_fault, 2'h0,
                                            st_reg.cfg.force_double_fault,
                                            st_reg.cfg.force_single_fault};
            `OFS_STATUS: st_next.rd_data = {st_reg.cmd_done, 1'h0, st_reg.acc_err, 5'h00};
            `OFS_ERR_STATUS: st_next.rd_data = {6'h00, st_reg.err_status};
            `OFS_ERR_MASK: st_next.rd_data = {6'h00, st_reg.err_mask};
            `OFS_CMD_IDX: st_next.rd_data = {5'h00, st_reg.cmd_idx};
            `OFS_CMD_HI: st_next.rd_data = (st_reg.cmd_idx < 3'h5) ?
                                           st_reg.params[st_reg.cmd_idx][15:8] : 8'h00;
            `OFS_CMD_LO: st_next.rd_data = (st_reg.cmd_idx < 3'h5) ?
                                           st_reg.params[st_reg.cmd_idx][7:0] : 8'h00;
            `OFS_ECC_HI: st_next.rd_data = ecc_word[15:8];
            `OFS_ECC_LO: st_next.rd_data = ecc_word[7:0];
            default: st_next.rd_data = 8'h00;
         endcase
      end
      if (wr_i) begin
         unique case (addr_i)
            `OFS_CONFIG: begin
               st_next.cfg.irq_en = wdata_i[`CFG_IRQ_EN_BIT];
               st_next.cfg.ignore_single_fault = wdata_i[`CFG_IGN_SF_BIT];
               st_next.cfg.force_double_fault = wdata_i[`CFG_FORCE_DF_BIT];
               st_next.cfg.force_single_fault = wdata_i[`CFG_FORCE_SF_BIT];
            end
            `OFS_ECC_IDX: st_next.ecc_idx = wdata_i[2:0];
            `OFS_ERR_MASK: st_next.err_mask = wdata_i[1:0];
            `OFS_STATUS: begin
               if (wdata_i[`STAT_ACCESS_ERROR_FLAG_BIT]) begin
                  st_next.acc_err = 1'b0;
               end
            end
            // parameters stay locked while a command runs
            `OFS_CMD_IDX: if (st_reg.cmd_done) st_next.cmd_idx = wdata_i[2:0];
            `OFS_CMD_HI: begin
               if (st_reg.cmd_done && st_reg.cmd_idx < 3'h5) begin
                  st_next.params[st_reg.cmd_idx][15:8] = wdata_i;
               end
            end
            `OFS_CMD_LO: begin
               if (st_reg.cmd_done && st_reg.cmd_idx < 3'h5) begin
                  st_next.params[st_reg.cmd_idx][7:0] = wdata_i;
               end
            end
            default: ;
         endcase
      end
      unique case (st_reg.fsm)
         flash_unsecure_pkg::IDLE: begin
            if (launch) begin
               if (st_reg.params[0][15:8] != `VERIFY_KEY_CMD || st_reg.cmd_idx != `LAUNCH_IDX
                   || st_reg.key_enable != `KEY_ENABLED
                   || st_reg.lockout) begin
                  st_next.acc_err = 1'b1;
               end else begin
                  st_next.cmd_done = 1'b0;
                  st_next.fsm = flash_unsecure_pkg::CHECK;
                  st_next.key_idx = 2'h0;
                  st_next.all_match = 1'b1;
               end
            end
         end
         flash_unsecure_pkg::CHECK: begin
            // one key per cycle; the stored keys are only read, never written
            st_next.all_match = st_reg.all_match && hit;
            st_next.key_idx = st_reg.key_idx + 2'h1;
            if (st_reg.key_idx == 2'(`KEY_COUNT - 1)) begin
               st_next.fsm = flash_unsecure_pkg::FINISH;
            end
         end
         flash_unsecure_pkg::FINISH: begin
            if (st_reg.all_match) begin
               // live state only; the security byte input is untouched
               st_next.security_state = `SEC_UNSECURE;
            end else begin
               st_next.lockout = 1'b1;
               st_next.acc_err = 1'b1;
            end
            st_next.cmd_done = 1'b1;
            st_next.fsm = flash_unsecure_pkg::IDLE;
         end
         default: st_next.fsm = flash_unsecure_pkg::IDLE;
      endcase
      if (!resetn_i) begin
         st_next = '0;
         st_next.fsm = flash_unsecure_pkg::IDLE;
         st_next.cmd_done = 1'b1;
         st_next.security_state = nv_security_i[1:0];
         st_next.key_enable = nv_security_i[7:6];
      end
   end

   always_ff @(posedge clk_i) begin
      st_reg <= st_next;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rdata_o = st_reg.rd_data;
   assign pf0_rd_data_o = st_reg.pf0_data;
   assign pf0_rd_invalid_o = st_reg.pf0_invalid;
   assign force_fault_o = {st_reg.cfg.force_double_fault, st_reg.cfg.force_single_fault};
   assign security_state_o = st_reg.security_state;
   assign key_program_allow_o = (st_reg.security_state == `SEC_UNSECURE);
   assign sector_erase_allow_o = (st_reg.security_state == `SEC_UNSECURE);
   assign irq_o = (st_reg.cmd_done && st_reg.cfg.irq_en)
                  || |(st_reg.err_status & st_reg.err_mask);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence seq_run;
      launch ##1 st_reg.fsm == flash_unsecure_pkg::CHECK;
   endsequence
   sequence seq_done;
      // four compare cycles plus the finish cycle keep the flag low
      !st_reg.cmd_done [*5] ##1 st_reg.cmd_done;
   endsequence

   done_after_run_a: assert property (seq_run |-> seq_done)
      else $error("done flag not back six cycles after start");
   unsecure_on_match_a: assert property (
      st_reg.fsm == flash_unsecure_pkg::FINISH && st_reg.all_match
      |=> st_reg.security_state == `SEC_UNSECURE && key_program_allow_o)
      else $error("match did not unsecure");
   key_gate_a: assert property (launch && st_reg.key_enable != `KEY_ENABLED
      |=> st_reg.acc_err && st_reg.cmd_done && !busy)
      else $error("disabled key enable did not give access error");
   blank_key_a: assert property (st_reg.fsm == flash_unsecure_pkg::CHECK
      && (stored_keys_i[st_reg.key_idx] == `KEY_BLANK_LO
      || stored_keys_i[st_reg.key_idx] == `KEY_BLANK_HI) |=> !st_reg.all_match)
      else $error("blank stored key matched");
   pf0_block_a: assert property (busy && pf0_rd_req_i
      |=> pf0_rd_invalid_o && pf0_rd_data_o == `INVALID_DATA)
      else $error("block 0 read not refused while busy");
   lockout_a: assert property (st_reg.lockout && launch
      |=> st_reg.acc_err && !busy && $stable(st_reg.security_state))
      else $error("locked out verification ran");
   lock_sticky_a: assert property (st_reg.lockout |=> st_reg.lockout)
      else $error("lockout cleared without reset");
   sec_stable_a: assert property (st_reg.fsm != flash_unsecure_pkg::FINISH
      |=> $stable(st_reg.security_state))
      else $error("security state moved outside a finished verification");
   done_irq_a: assert property (st_reg.cmd_done && st_reg.cfg.irq_en |-> irq_o)
      else $error("enabled done flag raised no interrupt");
   ignore_single_a: assert property (st_reg.cfg.ignore_single_fault && !st_reg.err_status.sgl
      |=> !st_reg.err_status.sgl)
      else $error("ignored single fault was reported");
   config_zero_a: assert property (rd_i && addr_i == `OFS_CONFIG
      |=> (rdata_o & ~`CFG_RW_MASK) == 8'h00)
      else $error("config reserved bits not zero");
   reset_reload_a: assert property (disable iff (1'b0) !resetn_i
      |=> security_state_o == $past(nv_security_i[1:0]) && !st_reg.lockout)
      else $error("security state not reloaded at reset");
endmodule : flash_backdoor_unsecure

// file: flash_backdoor_unsecure_tb.sv
// self-checking bench for the backdoor unsecure block
// assumes the constants header and package are compiled first; bench drives every port
`timescale 1ns/1ps
`include "flash_unsecure_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module flash_backdoor_unsecure_tb;
   logic clk_i, resetn_i, wr_i, rd_i, single_fault_i, double_fault_i, pf0_rd_req_i;
   logic [7:0] addr_i, wdata_i, rdata_o, nv_security_i, exp_rd;
   logic [15:0] pf0_array_data_i, pf0_rd_data_o;
   logic pf0_rd_invalid_o, key_program_allow_o, sector_erase_allow_o, irq_o, rd_d;
   logic [1:0] security_state_o;
   logic [31:0] seed;
   flash_unsecure_pkg::key_set_t stored_keys_i, keys, bad;
   flash_unsecure_pkg::ecc_set_t ecc_results_i;
   flash_unsecure_pkg::fault_t force_fault_o;
   logic [7:0] exp_q[$];
   int fail_count, checked, cycles;
   flash_backdoor_unsecure dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .nv_security_i(nv_security_i), .stored_keys_i(stored_keys_i),
      .ecc_results_i(ecc_results_i), .single_fault_i(single_fault_i),
      .double_fault_i(double_fault_i), .pf0_rd_req_i(pf0_rd_req_i),
      .pf0_array_data_i(pf0_array_data_i), .pf0_rd_data_o(pf0_rd_data_o),
      .pf0_rd_invalid_o(pf0_rd_invalid_o), .force_fault_o(force_fault_o),
      .security_state_o(security_state_o), .key_program_allow_o(key_program_allow_o),
      .sector_erase_allow_o(sector_erase_allow_o), .irq_o(irq_o));
   // ----------------------------------------
   // clock, watcher, timeout
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // read data stand only in the cycle after the strobe, so that is where they are taken
   always @(posedge clk_i) begin
      rd_d <= rd_i;
      if (rd_d === 1'b1) begin
         exp_rd = exp_q.pop_front();
         `CHK("rdata", exp_rd, rdata_o)
      end
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      addr_i <= a;
      wdata_i <= d;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      addr_i <= a;
      exp_q.push_back(e);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_i);
         wr_i <= 1'b0;
         rd_i <= 1'b0;
         pf0_rd_req_i <= 1'b0;
         single_fault_i <= 1'b0;
         double_fault_i <= 1'b0;
      end
   endtask : idle
   task automatic rst(input logic [7:0] nv);
      idle(1);
      resetn_i <= 1'b0;
      nv_security_i <= nv;
      idle(6);
      resetn_i <= 1'b1;
   endtask : rst
   task automatic fault(input logic s, input logic d);
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      single_fault_i <= s;
      double_fault_i <= d;
      idle(1);
   endtask : fault
   // loads command and keys, launches, probes block 0 two cycles after the launch write, then reads the outcome
   task automatic verify(input flash_unsecure_pkg::key_set_t k, input logic busy,
         input logic [7:0] stat, input logic [1:0] st);
      wr(`OFS_CMD_IDX, 8'h00);
      wr(`OFS_CMD_HI, `VERIFY_KEY_CMD);
      wr(`OFS_CMD_LO, 8'h00);
      for (int i = 0; i < `KEY_COUNT; i++) begin
         wr(`OFS_CMD_IDX, 8'(i + 1));
         wr(`OFS_CMD_HI, k[i][15:8]);
         wr(`OFS_CMD_LO, k[i][7:0]);
      end
      wr(`OFS_STATUS, 8'h80);
      idle(1);
      @(posedge clk_i);
      pf0_rd_req_i <= 1'b1;
      idle(2);
      `CHK("pf0_invalid", busy, pf0_rd_invalid_o)
      `CHK("pf0_data", busy ? `INVALID_DATA : pf0_array_data_i, pf0_rd_data_o)
      idle(6);
      rd(`OFS_STATUS, stat);
      idle(2);
      `CHK("security_state", st, security_state_o)
   endtask : verify
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {resetn_i, wr_i, rd_i, single_fault_i, double_fault_i, pf0_rd_req_i} = 6'h00;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      nv_security_i = 8'h81;
      seed = 32'h000172AD;
      for (int i = 0; i < `ECC_WORDS; i++) begin
         seed = lfsr(seed);
         ecc_results_i[i] = seed[15:0];
      end
      for (int i = 0; i < `KEY_COUNT; i++) begin
         seed = lfsr(seed);
         keys[i] = (seed[15:0] == 16'h0000 || seed[15:0] == 16'hFFFF) ? 16'h1234 : seed[15:0];
      end
      stored_keys_i = keys;
      pf0_array_data_i = 16'hA5C3;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(`OFS_SECURITY, 8'h81);
      rd(`OFS_STATUS, 8'h80);
      rd(8'h3F, 8'h00);
      wr(`OFS_CONFIG, 8'hFF);
      rd(`OFS_CONFIG, 8'h93);
      idle(2);
      `CHK("force_fault", 2'h3, force_fault_o)
      `CHK("irq_enabled", 1'b1, irq_o)
      wr(`OFS_CONFIG, 8'h00);
      idle(2);
      `CHK("irq_disabled", 1'b0, irq_o)
      $display("test registers done");
      for (int i = 0; i < `ECC_WORDS; i++) begin
         wr(`OFS_ECC_IDX, 8'(i));
         rd(`OFS_ECC_HI, ecc_results_i[i][15:8]);
         rd(`OFS_ECC_LO, ecc_results_i[i][7:0]);
      end
      $display("test ecc index done");
      wr(`OFS_CONFIG, 8'h10);
      fault(1'b1, 1'b0);
      rd(`OFS_ERR_STATUS, 8'h00);
      wr(`OFS_CONFIG, 8'h00);
      fault(1'b1, 1'b1);
      rd(`OFS_ERR_STATUS, 8'h03);
      idle(2);
      `CHK("irq_masked", 1'b0, irq_o)
      wr(`OFS_ERR_MASK, 8'h01);
      idle(2);
      `CHK("irq_fault", 1'b1, irq_o)
      wr(`OFS_ERR_STATUS, 8'h03);
      idle(2);
      `CHK("irq_cleared", 1'b0, irq_o)
      $display("test faults done");
      // stored blank words must never unlock, even when presented exactly
      for (int j = 0; j < 2; j++) begin
         rst(8'h81);
         bad = keys;
         bad[2] = j ? `KEY_BLANK_HI : `KEY_BLANK_LO;
         stored_keys_i <= bad;
         verify(bad, 1'b1, 8'hA0, 2'h1);
      end
      stored_keys_i <= keys;
      rst(8'h81);
      bad = keys;
      bad[3][0] = ~bad[3][0];
      verify(bad, 1'b1, 8'hA0, 2'h1);
      wr(`OFS_STATUS, 8'h20);
      verify(keys, 1'b0, 8'hA0, 2'h1);
      $display("test lockout done");
      rst(8'h81);
      wr(`OFS_CONFIG, 8'h80);
      verify(keys, 1'b1, 8'h80, `SEC_UNSECURE);
      `CHK("irq_done", 1'b1, irq_o)
      `CHK("key_program", 1'b1, key_program_allow_o)
      `CHK("sector_erase", 1'b1, sector_erase_allow_o)
      `CHK("stored_keys", keys, stored_keys_i)
      rst(8'h81);
      `CHK("reload_state", 2'h1, security_state_o)
      `CHK("key_locked", 1'b0, key_program_allow_o)
      $display("test unsecure done");
      for (int j = 0; j < 3; j++) begin
         rst({2'(j == 2 ? 3 : j), 6'h01});
         verify(keys, 1'b0, 8'hA0, 2'h1);
      end
      $display("test key enable done");
      end_of_test();
   end
endmodule : flash_backdoor_unsecure_tb
